/* File: hw/nfc_defines.vh */
// Summary of operation
// - Erase: setup code then three address cycles
// - Erase starts only on confirm code
// - Dual-plane: setup plus address at most twice
// - Write read code before resuming array reads
// - Host masks status bits unused by operation
// - Identification code, zero address, six bytes
`ifndef NFC_DEFINES_VH
`define NFC_DEFINES_VH

// Device command codes
`define NFC_CMD_READ 8'h00
`define NFC_CMD_ERASE_SETUP 8'h60
`define NFC_CMD_ERASE_CONFIRM 8'hD0
`define NFC_CMD_STATUS_BASIC 8'h70
`define NFC_CMD_STATUS_PLANE 8'hF1
`define NFC_CMD_IDENT 8'h90
`define NFC_CMD_RESET 8'hFF
`define NFC_ADDR_IDENT 8'h00
`define NFC_ERASE_ADDR_CYCLES 2'd3
`define NFC_IDENT_BYTES 3'd6
`define NFC_STATUS_AFTER_RESET 8'hC0

// Status bit positions
`define NFC_ST_FAIL 0
`define NFC_ST_PLANE0_FAIL 1
`define NFC_ST_PLANE1_FAIL 2
`define NFC_ST_TRUE_READY 5
`define NFC_ST_READY 6
`define NFC_ST_WP_N 7
// Mask of bits meaningful after an erase
`define NFC_ERASE_STATUS_MASK 8'hC7

// Controller register byte offsets
`define NFC_REG_CTRL 8'h00
`define NFC_REG_BLOCK0 8'h04
`define NFC_REG_BLOCK1 8'h08
`define NFC_REG_STATUS 8'h0C
`define NFC_REG_RESULT 8'h10
`define NFC_REG_ID_LO 8'h14
`define NFC_REG_ID_HI 8'h18

// Control register fields (a one in bits 0 to 6 starts; bit 8 drives write_protect_n high, lifting write protect)
`define NFC_CTRL_ERASE 0
`define NFC_CTRL_DUAL 1
`define NFC_CTRL_STATUS 2
`define NFC_CTRL_PLANE_VIEW 3
`define NFC_CTRL_IDENT 4
`define NFC_CTRL_RESET 5
`define NFC_CTRL_READ 6
`define NFC_CTRL_WP_HIGH 8

// Controller status fields
`define NFC_STAT_BUSY 0
`define NFC_STAT_DONE 1
`define NFC_STAT_ERASE_FAIL 2
`define NFC_STAT_RDY_PIN 3

// Pin timing: the strobe low phase lasts this many ns; the high phase lasts two clocks longer
`define NFC_PHASE_NS 40
`define NFC_CLK_NS 40
`define NFC_PHASE_CYC ((`NFC_PHASE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)

`endif

/* File: hw/nfc_sync2.v */
`timescale 1ns/1ns
`default_nettype none
module nfc_sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Data
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end
  assign dout = sync_ff;
endmodule // nfc_sync2
`default_nettype wire

/* File: hw/nfc_cycle.v */
`timescale 1ns/1ns
`default_nettype none
`include "nfc_defines.vh"
// One bus cycle on the flash pins: command, address, write or read byte.
module nfc_cycle #(
  parameter PHASE = `NFC_PHASE_CYC
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Request
  input wire req,
  input wire [1:0] kind,
  input wire [7:0] wdata,
  output wire ack,
  output reg [7:0] rdata_ff,
  // Flash pins (synchronised input)
  input wire [7:0] io_in_sync,
  output reg [7:0] io_out_ff,
  output reg io_oe_ff,
  output reg cle_ff,
  output reg ale_ff,
  output reg write_strobe_n_ff,
  output reg read_strobe_n_ff
);
  // kind: 0 command, 1 address, 2 read
  localparam S_IDLE = 3'b001;
  localparam S_LOW = 3'b010;
  localparam S_HIGH = 3'b100;
  localparam [7:0] PH = PHASE;
  reg [2:0] state_ff;
  reg [7:0] cnt_ff;
  reg rd_ff;
  reg ack_ff;
  assign ack = ack_ff;

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= S_IDLE;
      cnt_ff <= 8'h00;
      rd_ff <= 1'b0;
      ack_ff <= 1'b0;
      rdata_ff <= 8'h00;
      io_out_ff <= 8'h00;
      io_oe_ff <= 1'b0;
      cle_ff <= 1'b0;
      ale_ff <= 1'b0;
      write_strobe_n_ff <= 1'b1;
      read_strobe_n_ff <= 1'b1;
    end else begin
      ack_ff <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (req && !ack_ff) begin
            rd_ff <= (kind == 2'd2);
            cle_ff <= (kind == 2'd0);
            ale_ff <= (kind == 2'd1);
            io_out_ff <= wdata;
            io_oe_ff <= (kind != 2'd2);
            write_strobe_n_ff <= (kind == 2'd2);
            read_strobe_n_ff <= (kind != 2'd2);
            cnt_ff <= PH;
            state_ff <= S_LOW;
          end
        end
        S_LOW: begin
          if (cnt_ff > 8'h01) begin
            cnt_ff <= cnt_ff - 8'h01;
          end else begin
            write_strobe_n_ff <= 1'b1;
            read_strobe_n_ff <= 1'b1;
            cnt_ff <= PH + 8'h02;
            state_ff <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (cnt_ff > 8'h01) begin
            cnt_ff <= cnt_ff - 8'h01;
          end else begin
            // Sampled late: pin data needs two clocks through the synchroniser
            if (rd_ff) begin
              rdata_ff <= io_in_sync;
            end
            cle_ff <= 1'b0;
            ale_ff <= 1'b0;
            io_oe_ff <= 1'b0;
            ack_ff <= 1'b1;
            state_ff <= S_IDLE;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule // nfc_cycle
`default_nettype wire

/* File: hw/nfc_ctrl.v */
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "nfc_defines.vh"
module nfc_ctrl (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp_ff,
  output reg s_axi_bvalid_ff,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata_ff,
  output reg [1:0] s_axi_rresp_ff,
  output reg s_axi_rvalid_ff,
  input wire s_axi_rready,
  // Flash pins
  input wire [7:0] io_in,
  output wire [7:0] io_out,
  output wire io_oe,
  output wire chip_select_n,
  output wire cle,
  output wire ale,
  output wire write_strobe_n,
  output wire read_strobe_n,
  output wire write_protect_n,
  input wire ready_busy_n
);
  localparam S_IDLE = 8'h01;
  localparam S_CMD = 8'h02;
  localparam S_ADDR = 8'h04;
  localparam S_CONF = 8'h08;
  localparam S_WAIT = 8'h10;
  localparam S_STAT = 8'h20;
  localparam S_IDRD = 8'h40;
  localparam S_DONE = 8'h80;

  wire [7:0] io_sync;
  wire rdy_sync;
  reg [7:0] state_ff;
  reg [15:0] ctrl_ff;
  reg [23:0] block0_ff;
  reg [23:0] block1_ff;
  reg [7:0] result_ff;
  reg [47:0] ident_ff;
  reg busy_ff;
  reg done_ff;
  reg fail_ff;
  reg second_ff;
  reg rst_pend_ff;
  reg [1:0] acnt_ff;
  reg [2:0] icnt_ff;
  reg [1:0] op_ff;
  reg aw_got_ff;
  reg w_got_ff;
  reg [7:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg cyc_req_ff;
  reg [1:0] cyc_kind_ff;
  reg [7:0] cyc_data_ff;
  wire cyc_ack;
  wire [7:0] cyc_rdata;
  // Op codes for the engine
  localparam [1:0] OP_ERASE = 2'd0;
  localparam [1:0] OP_STAT = 2'd1;
  localparam [1:0] OP_IDENT = 2'd2;
  localparam [1:0] OP_SIMPLE = 2'd3;

  nfc_sync2 #(.WIDTH(9)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({ready_busy_n, io_in}),
    .dout({rdy_sync, io_sync})
  );

  nfc_cycle u_cycle (
    .aclk(aclk),
    .aresetn(aresetn),
    .req(cyc_req_ff),
    .kind(cyc_kind_ff),
    .wdata(cyc_data_ff),
    .ack(cyc_ack),
    .rdata_ff(cyc_rdata),
    .io_in_sync(io_sync),
    .io_out_ff(io_out),
    .io_oe_ff(io_oe),
    .cle_ff(cle),
    .ale_ff(ale),
    .write_strobe_n_ff(write_strobe_n),
    .read_strobe_n_ff(read_strobe_n)
  );

  assign chip_select_n = 1'b0;
  assign write_protect_n = ctrl_ff[`NFC_CTRL_WP_HIGH];

  ////////////////////////////////////////////////////////////////////////
  // Register write side
  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid_ff;
  assign s_axi_wready = !w_got_ff && !s_axi_bvalid_ff;
  wire wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid_ff;
  wire start = wr_fire && (awaddr_ff == `NFC_REG_CTRL) && !busy_ff;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      s_axi_bvalid_ff <= 1'b0;
      s_axi_bresp_ff <= 2'b00;
      ctrl_ff <= 16'h0100;
      block0_ff <= 24'h000000;
      block1_ff <= 24'h000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_bvalid_ff <= 1'b1;
        s_axi_bresp_ff <= 2'b00;
        case (awaddr_ff)
          `NFC_REG_CTRL: begin
            // Writes while busy are refused except a reset request
            if (!busy_ff || wdata_ff[`NFC_CTRL_RESET]) begin
              ctrl_ff <= wdata_ff[15:0];
            end else begin
              s_axi_bresp_ff <= 2'b10;
            end
          end
          `NFC_REG_BLOCK0: block0_ff <= wdata_ff[23:0];
          `NFC_REG_BLOCK1: block1_ff <= wdata_ff[23:0];
          default: s_axi_bresp_ff <= 2'b10;
        endcase
      end else if (s_axi_bvalid_ff && s_axi_bready) begin
        s_axi_bvalid_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read side
  assign s_axi_arready = !s_axi_rvalid_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid_ff <= 1'b0;
      s_axi_rdata_ff <= 32'h00000000;
      s_axi_rresp_ff <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid_ff <= 1'b1;
      s_axi_rresp_ff <= 2'b00;
      case (s_axi_araddr)
        `NFC_REG_CTRL: s_axi_rdata_ff <= {16'h0000, ctrl_ff};
        `NFC_REG_BLOCK0: s_axi_rdata_ff <= {8'h00, block0_ff};
        `NFC_REG_BLOCK1: s_axi_rdata_ff <= {8'h00, block1_ff};
        `NFC_REG_STATUS: s_axi_rdata_ff <= {28'h0000000, rdy_sync, fail_ff, done_ff, busy_ff};
        `NFC_REG_RESULT: s_axi_rdata_ff <= {24'h000000, result_ff};
        `NFC_REG_ID_LO: s_axi_rdata_ff <= ident_ff[31:0];
        `NFC_REG_ID_HI: s_axi_rdata_ff <= {16'h0000, ident_ff[47:32]};
        default: begin
          s_axi_rdata_ff <= 32'h00000000;
          s_axi_rresp_ff <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid_ff && s_axi_rready) begin
      s_axi_rvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command engine
  wire [23:0] cur_block = second_ff ? block1_ff : block0_ff;
  wire [7:0] start_cmd =
    wdata_ff[`NFC_CTRL_RESET] ? `NFC_CMD_RESET :
    wdata_ff[`NFC_CTRL_ERASE] ? `NFC_CMD_ERASE_SETUP :
    wdata_ff[`NFC_CTRL_IDENT] ? `NFC_CMD_IDENT :
    wdata_ff[`NFC_CTRL_STATUS] ?
      (wdata_ff[`NFC_CTRL_PLANE_VIEW] ? `NFC_CMD_STATUS_PLANE : `NFC_CMD_STATUS_BASIC) :
    `NFC_CMD_READ;
  wire [1:0] start_op =
    wdata_ff[`NFC_CTRL_RESET] ? OP_SIMPLE :
    wdata_ff[`NFC_CTRL_ERASE] ? OP_ERASE :
    wdata_ff[`NFC_CTRL_IDENT] ? OP_IDENT :
    wdata_ff[`NFC_CTRL_STATUS] ? OP_STAT : OP_SIMPLE;
  wire any_go = |wdata_ff[6:0];
  wire rst_go = wr_fire && (awaddr_ff == `NFC_REG_CTRL) && wdata_ff[`NFC_CTRL_RESET];
  wire rst_now = (rst_go || rst_pend_ff) && (!cyc_req_ff || cyc_ack);

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= S_IDLE;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      second_ff <= 1'b0;
      acnt_ff <= 2'd0;
      icnt_ff <= 3'd0;
      op_ff <= OP_SIMPLE;
      result_ff <= `NFC_STATUS_AFTER_RESET;
      ident_ff <= 48'h000000000000;
      cyc_req_ff <= 1'b0;
      cyc_kind_ff <= 2'd0;
      cyc_data_ff <= 8'h00;
      rst_pend_ff <= 1'b0;
    end else if (rst_now || (start && any_go && !cyc_req_ff)) begin
      // Reset waits for the pin cycle in flight, then cuts in, even over a reset
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      second_ff <= 1'b0;
      rst_pend_ff <= 1'b0;
      op_ff <= rst_now ? OP_SIMPLE : start_op;
      cyc_kind_ff <= 2'd0;
      cyc_data_ff <= rst_now ? `NFC_CMD_RESET : start_cmd;
      cyc_req_ff <= 1'b1;
      state_ff <= S_CMD;
    end else begin
      rst_pend_ff <= rst_pend_ff | rst_go;
      case (state_ff)
        S_IDLE: cyc_req_ff <= 1'b0;
        S_CMD: begin
          if (cyc_ack) begin
            acnt_ff <= 2'd0;
            icnt_ff <= 3'd0;
            if (op_ff == OP_ERASE) begin
              // Page bits are sent as written in the block register; the device drops them anyway
              cyc_kind_ff <= 2'd1;
              cyc_data_ff <= cur_block[7:0];
              state_ff <= S_ADDR;
            end else if (op_ff == OP_IDENT) begin
              cyc_kind_ff <= 2'd1;
              cyc_data_ff <= `NFC_ADDR_IDENT;
              state_ff <= S_ADDR;
            end else if (op_ff == OP_STAT) begin
              cyc_kind_ff <= 2'd2;
              state_ff <= S_STAT;
            end else begin
              cyc_req_ff <= 1'b0;
              state_ff <= S_WAIT;
            end
          end
        end
        S_ADDR: begin
          if (cyc_ack) begin
            if (op_ff == OP_IDENT) begin
              cyc_kind_ff <= 2'd2;
              state_ff <= S_IDRD;
            end else if (acnt_ff + 2'd1 < `NFC_ERASE_ADDR_CYCLES) begin
              acnt_ff <= acnt_ff + 2'd1;
              cyc_data_ff <= (acnt_ff == 2'd0) ? cur_block[15:8] : cur_block[23:16];
            end else if (ctrl_ff[`NFC_CTRL_DUAL] && !second_ff) begin
              // Second plane gets its own setup, never more than two
              second_ff <= 1'b1;
              acnt_ff <= 2'd0;
              cyc_kind_ff <= 2'd0;
              cyc_data_ff <= `NFC_CMD_ERASE_SETUP;
              state_ff <= S_CMD;
            end else begin
              cyc_kind_ff <= 2'd0;
              cyc_data_ff <= `NFC_CMD_ERASE_CONFIRM;
              state_ff <= S_CONF;
            end
          end
        end
        S_CONF: begin
          if (cyc_ack) begin
            cyc_req_ff <= 1'b0;
            state_ff <= S_WAIT;
          end
        end
        S_WAIT: begin
          // Allow the device time to pull busy low through the synchroniser
          if (acnt_ff != 2'd3) begin
            acnt_ff <= acnt_ff + 2'd1;
          end else if (rdy_sync) begin
            if (op_ff == OP_ERASE) begin
              cyc_req_ff <= 1'b1;
              cyc_kind_ff <= 2'd0;
              cyc_data_ff <= `NFC_CMD_STATUS_BASIC;
              op_ff <= OP_STAT;
              state_ff <= S_CMD;
            end else begin
              state_ff <= S_DONE;
            end
          end
        end
        S_STAT: begin
          if (cyc_ack) begin
            cyc_req_ff <= 1'b0;
            result_ff <= cyc_rdata;
            // Only bits meaningful for the erase are judged
            fail_ff <= cyc_rdata[`NFC_ST_FAIL] & ctrl_ff[`NFC_CTRL_ERASE];
            state_ff <= S_DONE;
          end
        end
        S_IDRD: begin
          if (cyc_ack) begin
            ident_ff <= {cyc_rdata, ident_ff[47:8]};
            icnt_ff <= icnt_ff + 3'd1;
            if (icnt_ff + 3'd1 == `NFC_IDENT_BYTES) begin
              cyc_req_ff <= 1'b0;
              state_ff <= S_DONE;
            end
          end
        end
        S_DONE: begin
          // Cells cut off by a reset are treated as undefined by software
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          cyc_req_ff <= 1'b0;
          state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule // nfc_ctrl
`default_nettype wire

/* File: verif/nfc_ctrl_props.sv */
`timescale 1ns/1ns
`default_nettype none
module nfc_ctrl_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Flash pins
  input wire logic [7:0] io_out,
  input wire logic io_oe,
  input wire logic cle,
  input wire logic ale,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n
);
  logic [7:0] last_ff;
  logic [3:0] acnt_ff, rcnt_ff;
  logic [2:0] nset_ff;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // Strobes are one clock low, so counting low clocks counts cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_ff <= 8'hFF;
      acnt_ff <= 4'h0;
      rcnt_ff <= 4'h0;
      nset_ff <= 3'h0;
    end else if (!write_strobe_n && cle) begin
      last_ff <= io_out;
      acnt_ff <= 4'h0;
      rcnt_ff <= 4'h0;
      nset_ff <= (io_out == 8'h60) ? nset_ff + 3'h1 : 3'h0;
    end else if (!write_strobe_n && ale) begin
      acnt_ff <= acnt_ff + 4'h1;
    end else if (!read_strobe_n) begin
      rcnt_ff <= rcnt_ff + 4'h1;
    end
  end
  ////////////////////////////////////////
  chk_addr_count:
    assert property (!write_strobe_n && cle && (io_out == 8'hD0 || io_out == 8'h60)
      && last_ff == 8'h60 |-> acnt_ff == 4'h3) else $error("erase address count wrong");
  chk_confirm_order:
    assert property (!write_strobe_n && cle && io_out == 8'hD0 |-> last_ff == 8'h60
      && nset_ff inside {3'h1, 3'h2}) else $error("confirm without setup");
  chk_ident_addr:
    assert property (!write_strobe_n && ale && last_ff == 8'h90 |-> io_out == 8'h00
      && acnt_ff == 4'h0) else $error("identify address wrong");
  chk_ident_reads:
    assert property (!read_strobe_n && last_ff == 8'h90 |-> rcnt_ff < 4'h6)
      else $error("too many identify reads");
  chk_write_drive:
    assert property ($fell(write_strobe_n) |-> io_oe && (cle || ale))
      else $error("write cycle not driven");
  chk_read_release:
    assert property ($fell(read_strobe_n) |-> !io_oe && !cle && !ale)
      else $error("bus driven in read");
  chk_write_pulse:
    assert property ($fell(write_strobe_n) |=> write_strobe_n [*3])
      else $error("write strobe timing");
  chk_read_pulse:
    assert property ($fell(read_strobe_n) |=> read_strobe_n [*3])
      else $error("read strobe timing");
  cover property (!write_strobe_n && cle && io_out == 8'hD0 && nset_ff == 3'h2);
  cover property (!write_strobe_n && cle && io_out == 8'hFF);
  cover property (!read_strobe_n && last_ff == 8'h90 && rcnt_ff == 4'h5);
endmodule // nfc_ctrl_props
`default_nettype wire

/* File: verif/nfc_flash_model.sv */
`timescale 1ns/1ns
`default_nettype none
module nfc_flash_model #(
  parameter int BUSY_CYC = 24,
  // Arbitrary identity bytes, first one sent first
  parameter logic [47:0] ID = 48'h5A3CA59669C3
) (
  // Pins
  input wire logic aclk,
  input wire logic [7:0] din,
  input wire logic cle,
  input wire logic ale,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_protect_n,
  output logic [7:0] dq,
  output logic ready_busy_n,
  // Bench side
  input wire logic fail_mode,
  output logic [23:0] erase_addr = 24'h0,
  output int n_erase = 0,
  output int n_reset = 0
);
  logic [7:0] mode = 8'h00, idv = 8'h00, lastv = 8'h00;
  logic [23:0] abuf = 24'h0;
  logic setup = 1'b0, fail = 1'b0;
  logic [1:0] pf = 2'b00;
  int busy = 0, acnt = 0, nblk = 0, hold = 0, idx = 0;
  wire logic rdy = (busy == 0);
  // True ready only means something in cached modes, so it reads zero here
  wire logic [7:0] sts = (mode == 8'hF1) ? {write_protect_n, rdy, 1'b0, 2'b00, pf, fail}
    : {write_protect_n, rdy, 1'b0, 4'h0, fail};
  wire logic [7:0] val = (mode == 8'h90) ? idv
    : (mode == 8'h70 || mode == 8'hF1) ? sts : abuf[7:0];
  assign ready_busy_n = rdy;
  // Released bus shows the opposite of the last byte, never a stale copy
  assign dq = (!chip_select_n && (hold > 0 || !read_strobe_n)) ? val : ~lastv;
  ////////////////////////////////////////
  always @(posedge aclk) begin
    if (busy > 0) busy <= busy - 1;
    hold <= !read_strobe_n ? 3 : (hold > 0 ? hold - 1 : 0);
    if (hold > 0 || !read_strobe_n) lastv <= val;
  end
  always @(negedge read_strobe_n) begin
    if (mode == 8'h90) begin
      idv <= ID[47 - 8 * idx -: 8];
      idx <= idx + 1;
    end
  end
  always @(posedge write_strobe_n) begin
    if (cle) begin
      if (din == 8'hFF) begin
        busy <= BUSY_CYC;
        fail <= 1'b0;
        pf <= 2'b00;
        mode <= 8'h00;
        setup <= 1'b0;
        nblk <= 0;
        n_reset <= n_reset + 1;
      end else if (din == 8'h60) begin
        setup <= 1'b1;
        acnt <= 0;
        nblk <= nblk + 1;
      end else if (din == 8'hD0 && setup && acnt == 3) begin
        busy <= BUSY_CYC;
        fail <= fail_mode;
        pf <= {nblk > 1 && fail_mode, fail_mode};
        n_erase <= n_erase + nblk;
        erase_addr <= abuf;
        setup <= 1'b0;
        nblk <= 0;
      end else begin
        mode <= din;
        setup <= 1'b0;
        nblk <= 0;
        idx <= 0;
      end
    end else if (ale) begin
      abuf <= {din, abuf[23:8]};
      acnt <= acnt + 1;
    end
  end
endmodule // nfc_flash_model
`default_nettype wire

/* File: verif/tb_nand_erase_status_id_reset.sv */
`timescale 1ns/1ns
`default_nettype none
`include "nfc_defines.vh"
module tb_nand_erase_status_id_reset;
  localparam logic [47:0] ID = 48'h5A3CA59669C3;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic fail_mode = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d, b0, b1;
  logic [1:0] r;
  logic [47:0] eid;
  wire logic awready, wready, bvalid, arready, rvalid, io_oe, cs_n, cle, ale, ws_n, rs_n;
  wire logic wp_n, rb_n;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [7:0] io_out, dq;
  wire logic [23:0] eaddr;
  int n_erase, n_reset, fails = 0, n_compared = 0, ne, nr;
  wire logic [7:0] io_in = io_oe ? io_out : dq;
  always #20 aclk = ~aclk;
  nfc_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp_ff(bresp), .s_axi_bvalid_ff(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata_ff(rdata), .s_axi_rresp_ff(rresp), .s_axi_rvalid_ff(rvalid),
    .s_axi_rready(rready), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .chip_select_n(cs_n), .cle(cle), .ale(ale), .write_strobe_n(ws_n),
    .read_strobe_n(rs_n), .write_protect_n(wp_n), .ready_busy_n(rb_n));
  nfc_flash_model #(.ID(ID)) dev_u (.aclk(aclk), .din(io_out), .cle(cle), .ale(ale),
    .chip_select_n(cs_n), .write_strobe_n(ws_n), .read_strobe_n(rs_n),
    .write_protect_n(wp_n), .dq(dq), .ready_busy_n(rb_n), .fail_mode(fail_mode),
    .erase_addr(eaddr), .n_erase(n_erase), .n_reset(n_reset));
  ////////////////////////////////////////
  task automatic chk_reg(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_resp(input string s, input logic [1:0] e, input logic [1:0] g);
    chk_reg(s, {30'h0, e}, {30'h0, g});
  endtask
  task automatic chk_dev(input string s, input logic [31:0] e, input logic [31:0] g);
    chk_reg(s, e, g);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ha, hw, go;
    @(posedge aclk);
    go = 1'b1;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (go) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      go = !(bvalid && bready);
      rs = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (!go) bready <= 1'b0;
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ha, go;
    @(posedge aclk);
    go = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (go) begin
      @(negedge aclk);
      ha = arvalid && arready;
      go = !(rvalid && rready);
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (!go) rready <= 1'b0;
    end
  endtask
  task automatic ctl(input logic [31:0] v);
    int k;
    axw(`NFC_REG_CTRL, v, r);
    k = 0;
    d = 32'h1;
    while (d[0] !== 1'b0 && k < 400) begin
      axr(`NFC_REG_STATUS, d, r);
      k++;
    end
    if (k >= 400) begin
      fails++;
      $display("[ERR] busy expected 0 seen 1");
    end
  endtask
  function automatic logic [7:0] est(input logic pl, f, du, wp);
    est = pl ? {wp, 2'b10, 2'b00, du & f, f, f} : {wp, 2'b10, 4'h0, f};
  endfunction
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #(40 * 50000);
    fails++;
    $display("[ERR] run expected end seen hang");
    finish_test;
  end
  initial begin
    void'($urandom(32'h7cc4c87c));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(`NFC_REG_RESULT, d, r);
    chk_reg("result at reset", 32'hC0, {24'h0, d[7:0]});
    axr(8'h40, d, r);
    chk_resp("unmapped read", 2'b10, r);
    axw(8'h40, 32'h0, r);
    chk_resp("unmapped write", 2'b10, r);
    $display("reset values test done");
    for (int i = 0; i < 4; i++) begin
      b0 = $urandom & 32'hFFFFFF;
      b1 = $urandom & 32'hFFFFFF;
      fail_mode <= i[0];
      axw(`NFC_REG_BLOCK0, b0, r);
      axw(`NFC_REG_BLOCK1, b1, r);
      ne = n_erase;
      axw(`NFC_REG_CTRL, 32'h101 | {30'h0, i[1], 1'b0}, r);
      chk_resp("erase start", 2'b00, r);
      ctl(32'h101);
      chk_dev("blocks erased", ne + 1 + i[1], n_erase);
      chk_dev("erase address", i[1] ? b1 : b0, eaddr);
      chk_reg("erase fail", {31'h0, i[0]}, {31'h0, d[2]});
      chk_reg("ready pin", 32'h1, {31'h0, d[3]});
      axr(`NFC_REG_RESULT, d, r);
      chk_reg("basic status", est(0, i[0], i[1], 1) & `NFC_ERASE_STATUS_MASK,
        d[7:0] & `NFC_ERASE_STATUS_MASK);
      ctl(32'h10C);
      axr(`NFC_REG_RESULT, d, r);
      chk_reg("plane status", est(1, i[0], i[1], 1), d[7:0]);
    end
    $display("erase test done");
    ctl(32'h004);
    axr(`NFC_REG_RESULT, d, r);
    chk_reg("protected status", est(0, 1, 1, 0), d[7:0]);
    $display("protect test done");
    ctl(32'h110);
    for (int k = 0; k < 6; k++) eid[8 * k +: 8] = ID[47 - 8 * k -: 8];
    axr(`NFC_REG_ID_LO, d, r);
    chk_reg("id low", eid[31:0], d);
    axr(`NFC_REG_ID_HI, d, r);
    chk_reg("id high", {16'h0, eid[47:32]}, {16'h0, d[15:0]});
    $display("identify test done");
    fail_mode <= 1'b1;
    nr = n_reset;
    axw(`NFC_REG_CTRL, 32'h101, r);
    axw(`NFC_REG_CTRL, 32'h120, r);
    chk_resp("reset in erase", 2'b00, r);
    axw(`NFC_REG_CTRL, 32'h120, r);
    chk_resp("reset in reset", 2'b00, r);
    ctl(32'h120);
    ctl(32'h140);
    chk_dev("reset seen", 1, int'(n_reset > nr));
    ctl(32'h104);
    axr(`NFC_REG_RESULT, d, r);
    chk_reg("status after reset", 32'hC0, {24'h0, d[7:0]});
    $display("reset test done");
    finish_test;
  end
endmodule // tb_nand_erase_status_id_reset
bind nfc_ctrl nfc_ctrl_props chk_u (.aclk(aclk), .aresetn(aresetn), .io_out(io_out),
  .io_oe(io_oe), .cle(cle), .ale(ale), .write_strobe_n(write_strobe_n),
  .read_strobe_n(read_strobe_n));
`default_nettype wire
